/* core/pdmc_ctrl.sv */
/*
 power-down mode controller: sleep, software standby and hardware standby
 sequencing, plus the power control register on a plain strobe port.
 assumes the cpu pulses halt_exec for one cycle on the halt-wait instruction,
 and interrupt logic presents wake requests as same-clock levels.
*/
// What this block does
// - halt with select 0 enters sleep
// - sleep stops cpu, clock and modules run
// - halt with select 1 enters software standby
// - soft standby stops clock, reinitialises modules
// - standby pin low forces hardware standby
// - defined wake sources leave each mode
// - interrupt wake keeps select bit set
// - settling field picks 8192 to 131072 states
// - no cpu or module clock while settling
// - interrupt wake settles, services, then resumes
// - reset pin wake clears select bit
// - hardware standby left via reset rising edge
`timescale 1ns/1ps
module pdmc_ctrl
    import pdmc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              halt_exec,
    input  wire pdmc_wake_t        wake,
    input  wire logic              standby_in_pin_n,
    input  wire logic              chip_init_pin_n,
    output pdmc_ctl_t              ctl,
    output pdmc_state_t            mode
);

    pdmc_state_t   state_r;
    pdmc_state_t   state_nxt;
    logic [7:0]    pwr_ctrl_r;
    logic [7:0]    pwr_ctrl_nxt;
    logic [7:0]    rdata_r;
    logic [2:0]    standby_in_pin_n_sync_r;
    logic [2:0]    init_sync_r;
    logic          standby_in_pin_n_n_r;
    logic          init_n_r;
    logic          init_rise;
    logic          settle_done;
    logic [SETTLE_W-1:0] settle_terminal;
    pdmc_ctl_t     ctl_nxt;
    pdmc_ctl_t     ctl_r;

    // pin synchronisers; a change is taken once stages 2 and 3 agree
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            standby_in_pin_n_sync_r <= 3'h7;
            init_sync_r <= 3'h7;
            standby_in_pin_n_n_r    <= 1'b1;
            init_n_r    <= 1'b1;
        end
        else
        begin
            standby_in_pin_n_sync_r <= {standby_in_pin_n_sync_r[1:0], standby_in_pin_n};
            init_sync_r <= {init_sync_r[1:0], chip_init_pin_n};
            if (standby_in_pin_n_sync_r[1] == standby_in_pin_n_sync_r[2])
                standby_in_pin_n_n_r <= standby_in_pin_n_sync_r[2];
            if (init_sync_r[1] == init_sync_r[2])
                init_n_r <= init_sync_r[2];
        end
    end

    wire logic init_fil = (init_sync_r[1] == init_sync_r[2]) ? init_sync_r[2] : init_n_r;
    wire logic standby_in_pin_n_fil = (standby_in_pin_n_sync_r[1] == standby_in_pin_n_sync_r[2]) ? standby_in_pin_n_sync_r[2] : standby_in_pin_n_n_r;
    assign init_rise = init_fil && !init_n_r;

    // register decode
    wire logic       hit_pwr   = (reg_addr == SYS_PWR_CTRL_OFS);
    wire logic       wr_pwr    = reg_wr && hit_pwr;
    wire logic [2:0] settle_sel = pwr_ctrl_r[SETTLE_HI:SETTLE_LO];
    wire logic       soft_sel  = pwr_ctrl_r[SOFT_STANDBY_IN_PIN_N_BIT];
    wire logic       ext_wake  = wake.nmi | wake.ext_req_0 | wake.ext_req_1 | wake.ext_req_2;

    // settling terminal count; top bit set means the longest
    assign settle_terminal = settle_sel[2]        ? SETTLE_128K :
                             (settle_sel == 3'h3) ? SETTLE_64K  :
                             (settle_sel == 3'h2) ? SETTLE_32K  :
                             (settle_sel == 3'h1) ? SETTLE_16K  : SETTLE_8K;

    // mode sequencing; standby pin outranks everything
    always_comb
    begin
        state_nxt = state_r;
        if (!standby_in_pin_n_fil)
            state_nxt = PDMC_HW_STANDBY_IN_PIN_N;
        else
        begin
            case (state_r)
                PDMC_RUN:
                    if (halt_exec)
                        state_nxt = soft_sel ? PDMC_SOFT_STANDBY_IN_PIN_N : PDMC_SLEEP;
                PDMC_SLEEP:
                    if (!init_fil)
                        state_nxt = PDMC_RESET_HOLD;
                    else if (wake.any_irq || ext_wake)
                        state_nxt = PDMC_RUN;
                PDMC_SOFT_STANDBY_IN_PIN_N:
                    if (!init_fil)
                        state_nxt = PDMC_RESET_HOLD;
                    else if (ext_wake)
                        state_nxt = PDMC_SETTLE;
                PDMC_SETTLE:
                    if (!init_fil)
                        state_nxt = PDMC_RESET_HOLD;
                    else if (settle_done)
                        state_nxt = PDMC_RUN;
                PDMC_HW_STANDBY_IN_PIN_N:
                    state_nxt = PDMC_RESET_HOLD;
                PDMC_RESET_HOLD:
                    if (init_rise)
                        state_nxt = PDMC_RUN;
                default:
                    state_nxt = PDMC_RUN;
            endcase
        end
    end

    // register update; hardware clears select on reset-pin exit, writes touch bits 7..4
    always_comb
    begin
        pwr_ctrl_nxt = pwr_ctrl_r;
        if (wr_pwr)
            pwr_ctrl_nxt = (reg_wdata & SYS_PWR_CTRL_WMASK) | (pwr_ctrl_r & SYS_PWR_CTRL_KEEP);
        if (state_r == PDMC_RESET_HOLD || state_r == PDMC_HW_STANDBY_IN_PIN_N)
            pwr_ctrl_nxt = SYS_PWR_CTRL_RST;
    end

    // control outputs per mode; interrupt wake leaves the select bit alone
    always_comb
    begin
        ctl_nxt               = '0;
        ctl_nxt.osc_en        = 1'b1;
        ctl_nxt.cpu_clk_en    = 1'b1;
        ctl_nxt.periph_clk_en = 1'b1;
        case (state_nxt)
            PDMC_SLEEP:
                ctl_nxt.cpu_clk_en = 1'b0;
            PDMC_SOFT_STANDBY_IN_PIN_N:
            begin
                ctl_nxt.cpu_clk_en    = 1'b0;
                ctl_nxt.periph_clk_en = 1'b0;
                ctl_nxt.osc_en        = 1'b0;
                ctl_nxt.periph_init   = 1'b1;
            end
            PDMC_SETTLE:
            begin
                ctl_nxt.cpu_clk_en    = 1'b0;
                ctl_nxt.periph_clk_en = 1'b0;
            end
            PDMC_HW_STANDBY_IN_PIN_N:
            begin
                ctl_nxt.cpu_clk_en    = 1'b0;
                ctl_nxt.periph_clk_en = 1'b0;
                ctl_nxt.osc_en        = 1'b0;
                ctl_nxt.periph_init   = 1'b1;
                ctl_nxt.cpu_reg_clear = 1'b1;
                ctl_nxt.io_float      = 1'b1;
            end
            PDMC_RESET_HOLD:
            begin
                ctl_nxt.cpu_clk_en    = 1'b0; // oscillator runs while pin low
                ctl_nxt.periph_clk_en = 1'b0;
                ctl_nxt.periph_init   = 1'b1;
            end
            default:
            begin
                ctl_nxt.reset_seq  = (state_r == PDMC_RESET_HOLD);
                ctl_nxt.resume_irq = (state_r == PDMC_SETTLE);
            end
        endcase
    end

    pdmc_settle_timer u_settle
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (state_r == PDMC_SOFT_STANDBY_IN_PIN_N && state_nxt == PDMC_SETTLE),
        .terminal (settle_terminal),
        .done     (settle_done)
    );

    // state, register and registered outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r    <= PDMC_RUN;
            pwr_ctrl_r <= SYS_PWR_CTRL_RST;
            rdata_r    <= 8'h00;
            ctl_r      <= 8'he0;
        end
        else
        begin
            state_r    <= state_nxt;
            pwr_ctrl_r <= pwr_ctrl_nxt;
            rdata_r    <= (reg_rd && hit_pwr) ? pwr_ctrl_r : 8'h00; // unmapped reads zero
            ctl_r      <= ctl_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign ctl       = ctl_r;
    assign mode      = state_r;

endmodule : pdmc_ctrl

/* core/pdmc_pkg.sv */
/*
 power-down mode controller package: register offset, field layout,
 reset value, settling counts, mode states and carrier structs.
 assumes a single 125 MHz system clock domain.
*/
package pdmc_pkg;

    localparam int unsigned      ADDR_W             = 16;
    localparam logic [15:0]      SYS_PWR_CTRL_OFS   = 16'hffc4;
    localparam logic [7:0]       SYS_PWR_CTRL_RST   = 8'h09;
    localparam int unsigned      SOFT_STANDBY_IN_PIN_N_BIT      = 7;
    localparam int unsigned      SETTLE_HI          = 6;
    localparam int unsigned      SETTLE_LO          = 4;
    localparam logic [7:0]       SYS_PWR_CTRL_WMASK = 8'hf0;
    localparam logic [7:0]       SYS_PWR_CTRL_KEEP  = 8'h0f;
    localparam int unsigned      SETTLE_W           = 18;

    // settling counts in states (one state is one clock)
    localparam logic [17:0]      SETTLE_8K          = 18'h02000;
    localparam logic [17:0]      SETTLE_16K         = 18'h04000;
    localparam logic [17:0]      SETTLE_32K         = 18'h08000;
    localparam logic [17:0]      SETTLE_64K         = 18'h10000;
    localparam logic [17:0]      SETTLE_128K        = 18'h20000;
    localparam logic [17:0]      SETTLE_ONE         = 18'h00001;
    localparam logic [17:0]      SETTLE_ZERO        = 18'h00000;

    typedef enum logic [2:0] {
        PDMC_RUN,
        PDMC_SLEEP,
        PDMC_SOFT_STANDBY_IN_PIN_N,
        PDMC_SETTLE,
        PDMC_HW_STANDBY_IN_PIN_N,
        PDMC_RESET_HOLD
    } pdmc_state_t;

    // wake requests that reach the controller
    typedef struct packed {
        logic nmi;
        logic ext_req_0;
        logic ext_req_1;
        logic ext_req_2;
        logic any_irq;
    } pdmc_wake_t;

    // controls driven to the rest of the chip
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic periph_init;
        logic cpu_reg_clear;
        logic io_float;
        logic reset_seq;
        logic resume_irq;
    } pdmc_ctl_t;

endpackage : pdmc_pkg

/* core/pdmc_settle_timer.sv */
/*
 settling timer: counts oscillator states up to a terminal count and
 reports done; the clock-enable gating lives in the caller.
 assumes the oscillator clock is the system clk here.
*/
`timescale 1ns/1ps
module pdmc_settle_timer
    import pdmc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                start,
    input  wire logic [SETTLE_W-1:0] terminal,
    output logic                     done
);

    logic [SETTLE_W-1:0] cnt_r;
    logic [SETTLE_W-1:0] cnt_nxt;
    logic                run_r;
    logic                run_nxt;
    wire  logic          hit = run_r && (cnt_r == terminal - SETTLE_ONE);

    // next count; start restarts from zero
    assign cnt_nxt = start ? SETTLE_ZERO : (run_r ? cnt_r + SETTLE_ONE : cnt_r);
    assign run_nxt = start ? 1'b1 : (hit ? 1'b0 : run_r);

    // counter register, one state per clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= SETTLE_ZERO;
            run_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end

    assign done = hit;

endmodule : pdmc_settle_timer

/* testbench/pdmc_ctrl_props.sv */
/* checker for pdmc_ctrl: mode entry, clock gating, settling length.
   assumes one clk domain; bound to every pdmc_ctrl instance. */
`timescale 1ns/1ps
module pdmc_ctrl_props
    import pdmc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              halt_exec,
    input wire pdmc_wake_t        wake,
    input wire logic              standby_in_pin_n,
    input wire logic              chip_init_pin_n,
    input wire pdmc_ctl_t         ctl,
    input wire pdmc_state_t       mode
);
    logic [3:0]  sh_r;
    logic [17:0] cnt_r;
    logic [17:0] n_exp;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow of the power bits; hardware standby wipes them
    always_ff @(posedge clk)
    begin
        if (!rst_n || mode == PDMC_HW_STANDBY_IN_PIN_N || mode == PDMC_RESET_HOLD) sh_r <= 4'h0;
        else if (reg_wr && reg_addr == SYS_PWR_CTRL_OFS) sh_r <= reg_wdata[7:4];
    end
    // states spent settling, too long for a repetition
    always_ff @(posedge clk)
        cnt_r <= (rst_n && mode == PDMC_SETTLE) ? cnt_r + 18'h00001 : 18'h00000;
    assign n_exp = sh_r[2] ? SETTLE_128K : (SETTLE_8K << sh_r[1:0]);
    chk_sleep_entry: assert property (
        mode == PDMC_RUN && halt_exec && !sh_r[3]
        |=> mode inside {PDMC_SLEEP, PDMC_HW_STANDBY_IN_PIN_N, PDMC_RESET_HOLD}) else $error("no sleep");
    chk_soft_entry: assert property (
        mode == PDMC_RUN && halt_exec && sh_r[3]
        |=> mode inside {PDMC_SOFT_STANDBY_IN_PIN_N, PDMC_HW_STANDBY_IN_PIN_N, PDMC_RESET_HOLD}) else $error("no standby_in_pin_n");
    chk_sleep_clocks: assert property (
        mode == PDMC_SLEEP |-> !ctl.cpu_clk_en && ctl.periph_clk_en) else $error("sleep clk");
    chk_soft_clocks: assert property (
        mode == PDMC_SOFT_STANDBY_IN_PIN_N |-> !ctl.cpu_clk_en && !ctl.periph_clk_en) else $error("standby_in_pin_n clk");
    chk_hw_float: assert property (
        mode == PDMC_HW_STANDBY_IN_PIN_N |-> ctl.io_float && !ctl.cpu_clk_en) else $error("hw float");
    chk_soft_wake_src: assert property (
        mode == PDMC_SOFT_STANDBY_IN_PIN_N && !wake.nmi && !wake.ext_req_0 && !wake.ext_req_1
        && !wake.ext_req_2 |=> mode != PDMC_SETTLE && mode != PDMC_RUN) else $error("bad wake");
    chk_settle_gate: assert property (
        mode == PDMC_SETTLE |-> !ctl.cpu_clk_en && !ctl.periph_clk_en && ctl.osc_en)
        else $error("settle clk");
    chk_settle_len: assert property (
        mode == PDMC_SETTLE ##1 mode == PDMC_RUN |-> cnt_r >= n_exp && cnt_r <= n_exp + 18'h2)
        else $error("settle length");
    chk_resume_pulse: assert property (
        mode == PDMC_SETTLE ##1 mode == PDMC_RUN |-> ctl.resume_irq) else $error("no resume");
    chk_reset_seq: assert property (
        mode == PDMC_RESET_HOLD ##1 mode == PDMC_RUN |-> ctl.reset_seq) else $error("no reset");
    cov_sleep: cover property (mode == PDMC_SLEEP ##1 mode == PDMC_RUN);
    cov_settle: cover property (mode == PDMC_SETTLE ##1 mode == PDMC_RUN);
    cov_hw: cover property (mode == PDMC_HW_STANDBY_IN_PIN_N ##1 mode == PDMC_RESET_HOLD);
endmodule : pdmc_ctrl_props

bind pdmc_ctrl pdmc_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_exec(halt_exec), .wake(wake), .standby_in_pin_n(standby_in_pin_n),
    .chip_init_pin_n(chip_init_pin_n), .ctl(ctl), .mode(mode));

/* testbench/pdmc_cpu_model.sv */
/* cpu, interrupt and pin model on the far side of pdmc_ctrl.
   assumes its tasks are called from the bench in the clk domain. */
`timescale 1ns/1ps
module pdmc_cpu_model
    import pdmc_pkg::*;
(
    input  wire logic  clk,
    output logic       halt_exec,
    output pdmc_wake_t wake,
    output logic       standby_in_pin_n,
    output logic       chip_init_pin_n
);
    // idle: no halt, no request, both pins released high
    initial
    begin
        halt_exec = 1'b0;
        wake = '0;
        standby_in_pin_n = 1'b1;
        chip_init_pin_n = 1'b1;
    end
    // halt-wait executed: one-cycle pulse
    task automatic halt();
        @(posedge clk);
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
    endtask : halt
    // request levels held until the bench drops them
    task automatic req(logic [4:0] w);
        @(posedge clk);
        wake <= pdmc_wake_t'(w);
    endtask : req
    task automatic pins(logic s, logic i);
        @(posedge clk);
        standby_in_pin_n <= s;
        chip_init_pin_n <= i;
    endtask : pins
endmodule : pdmc_cpu_model

/* testbench/pdmc_ctrl_tb.sv */
/* self-checking bench for pdmc_ctrl: register port, sleep, software
   standby with settling, reset pin and hardware standby.
   assumes pdmc_cpu_model drives the cpu and pin side. */
`timescale 1ns/1ps
module pdmc_ctrl_tb
    import pdmc_pkg::*;
;
    logic              clk, rst_n, reg_wr, reg_rd, halt_exec, standby_in_pin_n_n, init_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata, reg_rdata;
    pdmc_wake_t        wake;
    pdmc_ctl_t         ctl;
    pdmc_state_t       mode;
    int                errors = 0, n_checks = 0, n, k;

    pdmc_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
        .wake(wake), .standby_in_pin_n(standby_in_pin_n_n), .chip_init_pin_n(init_n), .ctl(ctl),
        .mode(mode));
    pdmc_cpu_model cpu (.clk(clk), .halt_exec(halt_exec), .wake(wake),
        .standby_in_pin_n(standby_in_pin_n_n), .chip_init_pin_n(init_n));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= SYS_PWR_CTRL_OFS;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(logic [15:0] a, logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(32'(reg_rdata), 32'(exp));
    endtask : rd
    // bounded wait; settling needs up to 32768 states here
    task automatic wt(pdmc_state_t m);
        n = 0;
        while (mode !== m && n < 40000)
        begin
            @(negedge clk);
            n++;
        end
        chk(32'(mode), 32'(m));
    endtask : wt
    task automatic t_sleep();
        wr(8'h00);
        cpu.halt();
        wt(PDMC_SLEEP);
        chk(32'({ctl.cpu_clk_en, ctl.periph_clk_en}), 32'h1);
        cpu.req(5'h01);
        wt(PDMC_RUN);
        cpu.req(5'h00);
    endtask : t_sleep
    task automatic t_soft(logic [2:0] code, logic [4:0] w);
        wr({1'b1, code, 4'h0});
        cpu.halt();
        wt(PDMC_SOFT_STANDBY_IN_PIN_N);
        chk(32'({ctl.cpu_clk_en, ctl.periph_clk_en, ctl.osc_en, ctl.periph_init}), 32'h1);
        cpu.req(5'h01);
        repeat (20) @(negedge clk);
        chk(32'(mode), 32'(PDMC_SOFT_STANDBY_IN_PIN_N));
        cpu.req(w);
        wt(PDMC_SETTLE);
        cpu.req(5'h00);
        chk(32'({ctl.cpu_clk_en, ctl.periph_clk_en, ctl.osc_en}), 32'h1);
        wt(PDMC_RUN);
        chk(32'(n >= (8192 << code) && n <= (8192 << code) + 4), 32'h1);
        rd(SYS_PWR_CTRL_OFS, {1'b1, code, 4'h9});
    endtask : t_soft
    task automatic t_pins();
        wr(8'h00);
        rd(SYS_PWR_CTRL_OFS, 8'h09);
        wr(8'h80);
        cpu.halt();
        wt(PDMC_SOFT_STANDBY_IN_PIN_N);
        cpu.pins(1'b1, 1'b0);
        wt(PDMC_RESET_HOLD);
        cpu.pins(1'b1, 1'b1);
        wt(PDMC_RUN);
        rd(SYS_PWR_CTRL_OFS, 8'h09);
        cpu.pins(1'b0, 1'b0);
        wt(PDMC_HW_STANDBY_IN_PIN_N);
        chk(32'({ctl.io_float, ctl.cpu_reg_clear, ctl.periph_init}), 32'h7);
        cpu.pins(1'b1, 1'b0);
        wt(PDMC_RESET_HOLD);
        cpu.pins(1'b1, 1'b1);
        wt(PDMC_RUN);
    endtask : t_pins
    // sleep left by each pin, soft standby left by the standby pin
    task automatic t_pin_wake();
        wr(8'h00);
        cpu.halt();
        wt(PDMC_SLEEP);
        cpu.pins(1'b1, 1'b0);
        wt(PDMC_RESET_HOLD);
        cpu.pins(1'b1, 1'b1);
        wt(PDMC_RUN);
        for (k = 0; k < 2; k++)
        begin
            wr({k[0], 7'h00});
            cpu.halt();
            wt(k[0] ? PDMC_SOFT_STANDBY_IN_PIN_N : PDMC_SLEEP);
            cpu.pins(1'b0, 1'b0);
            wt(PDMC_HW_STANDBY_IN_PIN_N);
            cpu.pins(1'b1, 1'b0);
            wt(PDMC_RESET_HOLD);
            cpu.pins(1'b1, 1'b1);
            wt(PDMC_RUN);
        end
    endtask : t_pin_wake
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(SYS_PWR_CTRL_OFS, 8'h09);
        rd(16'hffc5, 8'h00);
        wr(8'h5a);
        rd(SYS_PWR_CTRL_OFS, 8'h59);
        t_sleep();
        // short codes only: bench clock acts as external, longer codes cost too many cycles
        for (k = 0; k < 4; k++)
            t_soft((k == 3) ? 3'h0 : 3'(k), 5'h10 >> k);
        t_pins();
        t_pin_wake();
        end_sim();
    end
    // watchdog well past the summed settling counts
    initial
    begin
        #(8 * 90000);
        errors++;
        end_sim();
    end
endmodule : pdmc_ctrl_tb
